// [dv/apb_completer_model.sv]
// Completer stand-in: stalls for a set number of access cycles
module apb_completer_model (
   input wire logic clk,
   input wire logic sel,
   input wire logic penable,
   input wire logic [31:0] readWord,
   input wire logic [3:0] waits,
   input wire logic fail,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   int count; // Wait states given so far; cleared by the completing edge
   // Count stalled access cycles
   always_ff @(posedge clk) begin
      count <= (sel && penable && !pready) ? count + 1 : 0;
   end
   assign pready = sel && penable && count >= waits;
   assign pslverr = pready && fail;
   // Off-cycle data is inverted so a stale sample shows up
   assign prdata = pready ? readWord : ~readWord;
endmodule

// [dv/apb_requester_unit_tb_top.sv]
module apb_requester_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import apb_requester_pkg::*;
   logic clk = 0, reset = 1, reqValid = 0, reqReady, ansValid, penable, pwrite, pready, pslverr, fail = 0;
   apb_request_s req = '0;
   apb_answer_s ans;
   logic [15:0] psel;
   logic [31:0] paddr, pwdata, prdata, readWord = 32'h0;
   logic [3:0] pstrb, waits = 4'h0;
   logic [2:0] pprot;
   int failures = 0, total_checks = 0;
   logic ansValid2, penable2;
   apb_answer_s ans2;
   logic [15:0] psel2;
   logic [3:0] pstrb2;
   logic [2:0] pprot2;
   apb_requester_unit DUT (.clk(clk), .reset(reset), .reqValid(reqValid), .reqReady(reqReady), .req(req),
      .ansValid(ansValid), .ans(ans), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   apb_completer_model far (.clk(clk), .sel(|psel), .penable(penable), .readWord(readWord), .waits(waits),
      .fail(fail), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // Same requests into an APB2 build: it must ignore ready and error and drive no strobes
   apb_requester_unit #(.VERSION(2)) DUT2 (.clk(clk), .reset(reset), .reqValid(reqValid), .reqReady(),
      .req(req), .ansValid(ansValid2), .ans(ans2), .psel(psel2), .penable(penable2), .pwrite(), .paddr(),
      .pwdata(), .pstrb(pstrb2), .pprot(pprot2), .prdata(readWord), .pready(pready), .pslverr(fail));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One whole transfer, judged at every falling edge
   task automatic run(logic [3:0] t, logic w, logic [31:0] a, logic [3:0] s, logic [3:0] n, logic f);
      int k;
      @(negedge clk);
      req = '{target: t, write: w, addr: a, wdata: ~a, strb: s, prot: 3'h5};
      readWord = {a[15:0], a[31:16]};
      waits = n;
      fail = f;
      reqValid = 1;
      @(negedge clk);
      reqValid = 0;
      check("setup", {psel, penable}, {16'h1 << t, 1'b0});
      check("direction", {pwrite, pstrb}, {w, w ? s : 4'h0});
      check("pins", {paddr, pwdata}, {a, ~a});
      check("prot", pprot, 3'h5);
      for (k = 0; k < 20 && !ansValid; k++) begin
         @(negedge clk);
         if (!ansValid) check("access", {psel, penable, pwrite, paddr}, {16'h1 << t, 1'b1, w, a});
      end
      check("waits", k, n + 2);
      check("answer", {ans.failed, ans.rdata}, {f, w ? 32'h0 : readWord});
      @(negedge clk);
      check("pulse", {ansValid, reqReady, psel}, {1'b0, 1'b1, 16'h0});
   endtask
   task automatic test_write();
      run(4'h3, 1'b1, 32'h1234_5678, 4'h9, 4'h0, 1'b0);
      $display("write with strobes done");
   endtask
   task automatic test_read_waits();
      run(4'hF, 1'b0, 32'hCAFE_0004, 4'hF, 4'h3, 1'b0);
      $display("read with waits done");
   endtask
   task automatic test_error();
      run(4'h0, 1'b1, 32'h0000_0010, 4'hF, 4'h1, 1'b1);
      run(4'h1, 1'b0, 32'h0000_0020, 4'h0, 4'h0, 1'b1);
      $display("error answers done");
   endtask
   task automatic test_selects();
      for (int i = 0; i < 16; i++) run(i[3:0], i[0], 32'h100 * i, 4'hC, 4'h0, 1'b0);
      $display("select sweep done");
   endtask
   // APB2 build finishes in its second cycle while the APB4 build still waits
   task automatic test_apb2();
      fork
         run(4'h6, 1'b0, 32'h0000_0600, 4'hF, 4'h3, 1'b1);
         begin
            repeat (2) @(negedge clk);
            check("v2 setup", {psel2, penable2, pstrb2, pprot2}, {16'h0040, 1'b0, 4'h0, 3'h0});
            @(negedge clk);
            check("v2 access", {penable2, ansValid2}, 2'h2);
            @(negedge clk);
            check("v2 answer", {ansValid2, ans2.failed, ans2.rdata}, {2'h2, 32'h0600_0000});
         end
      join
      $display("APB2 build done");
   endtask
   // Reset in mid transfer: select, enable, strobes and protection drop at once and the port is idle again
   task automatic test_reset();
      @(negedge clk);
      req = '{target: 4'h9, write: 1'b1, addr: 32'h0000_0900, wdata: 32'h1, strb: 4'hF, prot: 3'h1};
      waits = 4'h5;
      reqValid = 1;
      @(negedge clk);
      reqValid = 0;
      @(negedge clk);
      reset = 1;
      @(negedge clk);
      check("reset pins", {psel, penable, pstrb, pprot}, {16'h0, 1'b0, 4'h0, 3'h0});
      check("reset handshake", {ansValid, reqReady}, 2'h1);
      reset = 0;
      @(negedge clk);
      check("released", {psel, penable, ansValid, reqReady}, {16'h0, 1'b0, 1'b0, 1'b1});
      $display("mid-run reset done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      reset = 0;
      test_write();
      test_read_waits();
      test_error();
      test_apb2();
      test_reset();
      test_selects();
      conclude();
   end
   // Cuts a hang short; the sequence needs about 130 cycles
   initial begin
      #50000;
      failures++;
      conclude();
   end
endmodule

// [logic/apb_requester_consts.svh]
`ifndef APB_REQUESTER_CONSTS_SVH
`define APB_REQUESTER_CONSTS_SVH
// Protocol version codes chosen at build time
`define APB_VER_2 2
`define APB_VER_3 3
`define APB_VER_4 4
// Largest number of completers served
`define APB_MAX_COMPLETERS 16
// Bits per byte strobe lane
`define APB_LANE_BITS 8
// Direction encodings on the write output
`define APB_DIR_READ 1'h0
`define APB_DIR_WRITE 1'h1
// Reset values
`define APB_STRB_NONE 4'h0
`define APB_PROT_RESET 3'h0
`endif

// [logic/apb_requester_pkg.sv]
package apb_requester_pkg;
   // Request from the network side
   typedef struct packed {
      logic [3:0] target;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] strb;
      logic [2:0] prot;
   } apb_request_s;
   // Answer back to the network side
   typedef struct packed {
      logic [31:0] rdata;
      logic failed;
   } apb_answer_s;
   // Transfer phases
   typedef enum logic [1:0] {
      IDLE = 2'b00,
      SETUP = 2'b01,
      ACCESS = 2'b10
   } apb_phase_e;
endpackage

// [logic/apb_requester_unit.sv]
// Function
// [RULE1] Build-time choice of APB2, APB3 or APB4
// [RULE2] Up to sixteen selects, one asserted
// [RULE3] Enable low in setup, high afterwards
// [RULE4] Direction zero reads, one writes
// [RULE5] APB4 strobe per byte of write data
// [RULE6] Strobes all zero on reads
// [RULE7] Ready low stretches access phase
// [RULE8] Error in completing cycle fails transfer
// [RULE9] Integrator ties error low if absent
// [RULE10] Protection and strobes only in APB4
// [RULE11] Ready and error only APB3/APB4
// [RULE12] Outputs stable; read data captured at completion
`include "apb_requester_consts.svh"
module apb_requester_unit #(
   parameter int VERSION = `APB_VER_4,
   parameter int COMPLETERS = `APB_MAX_COMPLETERS
) (
   input wire logic clk,
   input wire logic reset,
   // Request side: valid/ready handshake
   input wire logic reqValid,
   output logic reqReady,
   input wire apb_requester_pkg::apb_request_s req,
   // Answer side: one-cycle pulse with data
   output logic ansValid,
   output apb_requester_pkg::apb_answer_s ans,
   // APB requester pins
   output logic [COMPLETERS-1:0] psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   output logic [2:0] pprot,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import apb_requester_pkg::*;

   // Refuse builds the logic cannot serve; caught at elaboration, before any cycle runs
   if (VERSION < `APB_VER_2 || VERSION > `APB_VER_4) begin : g_bad_version // [RULE1]
      $error("VERSION must be 2, 3 or 4");
   end
   if (COMPLETERS < 1 || COMPLETERS > `APB_MAX_COMPLETERS) begin : g_bad_count // [RULE2]
      $error("COMPLETERS must be 1 to 16");
   end
   // One strobe per byte lane; a wider data bus would leave lanes without a strobe
   if ($bits(pwdata) != $bits(pstrb) * `APB_LANE_BITS) begin : g_bad_lanes // [RULE5]
      $error("strobe count must match write data lanes");
   end

   localparam bit HAS_WAIT = (VERSION >= `APB_VER_3); // Ready/error present
   localparam bit HAS_V4 = (VERSION == `APB_VER_4); // Strobes/protection present

   apb_phase_e phase; // Current phase
   apb_request_s held; // Request held for the whole transfer
   logic readyIn; // Effective ready after build choice
   logic errIn; // Effective error after build choice
   logic completing; // Access phase ends this cycle

   // APB2 has no ready/error pins: inputs are ignored, completion is fixed
   assign readyIn = HAS_WAIT ? pready : 1'b1; // [RULE11] [RULE7]
   assign errIn = HAS_WAIT ? pslverr : 1'b0; // [RULE11] [RULE9]
   assign completing = (phase == ACCESS) && readyIn; // [RULE7]
   assign reqReady = (phase == IDLE);

   // Phase sequencing; back-to-back costs one idle cycle, kept for simplicity
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase <= IDLE;
      end else begin
         unique case (phase)
            IDLE: begin
               if (reqValid) begin
                  phase <= SETUP;
               end
            end
            SETUP: begin
               phase <= ACCESS;
            end
            ACCESS: begin
               if (readyIn) begin // [RULE7]
                  phase <= IDLE;
               end
            end
            default: begin
               phase <= IDLE;
            end
         endcase
      end
   end

   // Capture request once; held unchanged until completion
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         held <= '0;
      end else if (phase == IDLE && reqValid) begin
         held <= req; // [RULE12]
      end
   end

   // Answer: read data sampled only in the completing cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ansValid <= 1'b0;
         ans <= '0;
      end else begin
         ansValid <= completing;
         if (completing) begin
            ans.failed <= errIn; // [RULE8]
            if (held.write == `APB_DIR_READ) begin
               ans.rdata <= prdata; // [RULE12]
            end else begin
               ans.rdata <= '0;
            end
         end
      end
   end

   // Pin drive from held state; outputs are registered values
   assign penable = (phase == ACCESS); // [RULE3]
   assign pwrite = held.write; // [RULE4]
   assign paddr = held.addr;
   assign pwdata = held.wdata;
   // Strobes forced to zero on reads; absent (zero) outside APB4
   assign pstrb = (HAS_V4 && held.write == `APB_DIR_WRITE) ? held.strb : `APB_STRB_NONE; // [RULE5] [RULE6] [RULE10]
   assign pprot = HAS_V4 ? held.prot : `APB_PROT_RESET; // [RULE10] [RULE1]

   apb_select_decode #(
      .COMPLETERS(COMPLETERS)
   ) u_sel (
      .target(held.target),
      .active(phase != IDLE),
      .sel(psel)
   );

   // Enable low in setup, high next cycle
   property p_enable_seq;
      @(posedge clk) disable iff (reset) (phase == SETUP) |-> !penable ##1 penable;
   endproperty
   a_enable_seq: assert property (p_enable_seq) else $error("enable sequence wrong"); // [RULE3]

   // At most one select line
   property p_sel_onehot;
      @(posedge clk) disable iff (reset) $onehot0(psel);
   endproperty
   a_sel_onehot: assert property (p_sel_onehot) else $error("more than one select"); // [RULE2]

   // Strobes zero on reads while selected
   property p_strb_read;
      @(posedge clk) disable iff (reset) (|psel && !pwrite) |-> (pstrb == '0);
   endproperty
   a_strb_read: assert property (p_strb_read) else $error("strobes active on read"); // [RULE6]

   // Wait state keeps access phase open
   property p_wait;
      @(posedge clk) disable iff (reset) (penable && !readyIn) |=> (penable && $stable(psel));
   endproperty
   a_wait: assert property (p_wait) else $error("transfer ended while not ready"); // [RULE7]

   // Answer one cycle after completion, carrying error
   property p_error;
      @(posedge clk) disable iff (reset) completing |=> (ansValid && ans.failed == $past(errIn));
   endproperty
   a_error: assert property (p_error) else $error("error not reported"); // [RULE8]

   // Outputs stable from setup to access
   property p_stable;
      @(posedge clk) disable iff (reset) (phase == SETUP) |=> $stable(paddr) && $stable(pwrite) && $stable(pwdata);
   endproperty
   a_stable: assert property (p_stable) else $error("outputs changed mid transfer"); // [RULE12]

   // Direction matches the captured request
   property p_dir;
      @(posedge clk) disable iff (reset) (reqReady && reqValid) |=> (pwrite == $past(req.write));
   endproperty
   a_dir: assert property (p_dir) else $error("direction mismatch"); // [RULE4]

   // APB2 completes in second cycle
   property p_v2;
      @(posedge clk) disable iff (reset) (!HAS_WAIT && phase == SETUP) |=> completing;
   endproperty
   a_v2: assert property (p_v2) else $error("APB2 transfer not two cycles"); // [RULE11]

   // Protection zero outside APB4
   property p_v4only;
      @(posedge clk) disable iff (reset) !HAS_V4 |-> (pprot == '0 && pstrb == '0);
   endproperty
   a_v4only: assert property (p_v4only) else $error("APB4 outputs active"); // [RULE10]

   // Select, direction, address, write data and strobes frozen while the completer stalls
   property p_hold;
      @(posedge clk) disable iff (reset) (phase == ACCESS && !readyIn) |=> $stable(psel) && $stable(pwrite)
         && $stable(paddr) && $stable(pwdata) && $stable(pstrb);
   endproperty
   a_hold: assert property (p_hold) else $error("pins moved during wait state"); // [RULE12]

   // Read data is the word seen at the completing edge
   property p_rdata_capture;
      @(posedge clk) disable iff (reset) (ansValid && !$past(pwrite)) |-> (ans.rdata == $past(prdata));
   endproperty
   a_rdata_capture: assert property (p_rdata_capture) else $error("read data not from completing cycle"); // [RULE12]

   // Exactly one select while enable is high, for a target that exists
   property p_enable_sel;
      @(posedge clk) disable iff (reset) (penable && (held.target < COMPLETERS)) |-> $onehot(psel);
   endproperty
   a_enable_sel: assert property (p_enable_sel) else $error("no single select in access"); // [RULE2]

   // Nothing selected or enabled between transfers
   property p_idle_quiet;
      @(posedge clk) disable iff (reset) (phase == IDLE) |-> (psel == '0 && !penable);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("pins active while idle"); // [RULE3]

   // One answer per transfer; the idle cycle keeps answers apart
   property p_ans_pulse;
      @(posedge clk) disable iff (reset) ansValid |=> !ansValid;
   endproperty
   a_ans_pulse: assert property (p_ans_pulse) else $error("answer longer than one cycle"); // [RULE12]

   // An APB2 build cannot report a failed transfer
   property p_v2_ok;
      @(posedge clk) disable iff (reset) (!HAS_WAIT && ansValid) |-> !ans.failed;
   endproperty
   a_v2_ok: assert property (p_v2_ok) else $error("APB2 build reported an error"); // [RULE11]
endmodule

// [logic/apb_select_decode.sv]
`include "apb_requester_consts.svh"
// One-hot select lines: only the targeted completer sees select
module apb_select_decode #(
   parameter int COMPLETERS = `APB_MAX_COMPLETERS
) (
   input wire logic [3:0] target,
   input wire logic active,
   output logic [COMPLETERS-1:0] sel
);
   genvar i;
   // One comparator per completer line
   generate
      for (i = 0; i < COMPLETERS; i++) begin : g_sel
         assign sel[i] = active && (target == 4'(i)); // [RULE2]
      end
   endgenerate
endmodule
